// ### rtl/pmu_pkg.sv
// constants, types and register map of the resource power sequencer
// assumes one 200 MHz clock; sequencer ticks come from the 32.768 kHz input
package pmu_pkg;
	// =========================================================
	// sizes
	localparam int NRES = 8;
	localparam int NCORE = 4;
	localparam int TW = 8;
	localparam int CW = 16;
	localparam int POR_W = 25;
	typedef logic [NRES-1:0] res_mask_t;
	typedef logic [TW-1:0] res_time_t;
	typedef enum logic [3:0] {
		RS_OFF = 4'h1,
		RS_UP = 4'h2,
		RS_ON = 4'h4,
		RS_DOWN = 4'h8
	} res_state_t;
	// =========================================================
	// resource slots
	localparam int R_STBY = 0;
	localparam int R_CSW = 1;
	localparam int R_CLIN = 2;
	localparam int R_XTAL = 3;
	localparam int R_PLL = 4;
	localparam int R_RET = 5;
	// =========================================================
	// register offsets
	localparam logic [7:0] A_MIN = 8'h00;
	localparam logic [7:0] A_TMR_RES = 8'h04;
	localparam logic [7:0] A_TMR_CNT = 8'h08;
	localparam logic [7:0] A_SEL = 8'h0C;
	localparam logic [7:0] A_TON = 8'h10;
	localparam logic [7:0] A_TOFF = 8'h14;
	localparam logic [7:0] A_DEPS = 8'h18;
	localparam logic [7:0] A_STATE = 8'h1C;
	localparam logic [7:0] A_PEND = 8'h20;
	localparam logic [7:0] A_STAT = 8'h24;
	localparam logic [7:0] A_CLKMAP = 8'h30;
	// status bit positions
	localparam int ST_REGS = 0;
	localparam int ST_WLRST = 1;
	localparam int ST_BTRST = 2;
	localparam int ST_DOZE = 3;
	localparam int ST_POR = 4;
	// reset values
	localparam res_mask_t MIN_RST = 8'h01;
	localparam res_time_t TIME_RST = 8'h00;
	localparam res_mask_t DEPS_RST = 8'h00;
	localparam res_mask_t MAP_RST = 8'h00;
	// =========================================================
	// timing
	localparam int CLK_KHZ = 200000;
	localparam int POR_MAX_MS = 110;
	localparam int POR_CYC = POR_MAX_MS * CLK_KHZ;
endpackage : pmu_pkg

// ### rtl/pmu_resource_sequencer.sv
// resource power sequencer top: demand, dependencies, slots, pins, registers
// assumes all inputs synchronous to sys_clk_i; the slow oscillator is sampled
`timescale 1ns/1ps
`default_nettype none
module pmu_resource_sequencer
	import pmu_pkg::*;
#(
	parameter int POR_CYCLES = pmu_pkg::POR_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic low_power_osc_clock_i,
	input wire logic wlan_power_request_i,
	input wire logic bt_power_request_i,
	input wire logic [pmu_pkg::NCORE-1:0] core_clk_req_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output pmu_pkg::res_mask_t res_en_o,
	output logic core_regs_on_o,
	output logic wlan_reset_o,
	output logic bt_reset_o,
	output logic main_clk_en_o,
	output logic deep_sleep_retention_o,
	output logic doze_o
);
	import pmu_pkg::*;

	// =========================================================
	// declarations
	logic lpo_q;
	logic tick;
	logic wr;
	logic por_done;
	logic regs_on;
	logic tmr_active;
	logic doze;
	res_mask_t min_q;
	res_mask_t tmr_res_q;
	logic [CW-1:0] tmr_cnt_q;
	logic [2:0] sel_q;
	res_time_t ton_q [NRES];
	res_time_t toff_q [NRES];
	res_mask_t deps_q [NRES];
	res_mask_t clkmap_q [NCORE];
	res_mask_t core_mask;
	res_mask_t demand;
	res_mask_t req;
	res_mask_t dep_up;
	res_mask_t deps_ok;
	res_mask_t start_on;
	res_mask_t start_off;
	res_mask_t st_on;
	res_mask_t st_off;
	res_mask_t st_pend;
	res_state_t state [NRES];
	res_time_t timer [NRES];
	logic [31:0] rd_val;

	// =========================================================
	// slow tick from the 32.768 kHz oscillator
	// rising edge of the sampled oscillator marks one sequencer cycle
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			lpo_q <= 1'b0;
		end else if (ce_i) begin
			lpo_q <= low_power_osc_clock_i;
		end
	end
	assign tick = ce_i & low_power_osc_clock_i & ~lpo_q;

	// =========================================================
	// power-on reset release
	por_release #(
		.CYCLES(POR_CYCLES)
	) u_por (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.done_o(por_done)
	);

	// =========================================================
	// register writes
	assign wr = reg_wr_i & ce_i;

	// minimum resource mask
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			min_q <= MIN_RST;
		end else if (wr && reg_addr_i == A_MIN) begin
			min_q <= reg_wdata_i[NRES-1:0];
		end
	end

	// request timer resource mask
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tmr_res_q <= '0;
		end else if (wr && reg_addr_i == A_TMR_RES) begin
			tmr_res_q <= reg_wdata_i[NRES-1:0];
		end
	end

	// request timer: loaded by software, counts slow ticks
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tmr_cnt_q <= '0;
		end else if (wr && reg_addr_i == A_TMR_CNT) begin
			tmr_cnt_q <= reg_wdata_i[CW-1:0];
		end else if (tick && tmr_active) begin
			tmr_cnt_q <= tmr_cnt_q - 16'h0001;
		end
	end
	assign tmr_active = (tmr_cnt_q != '0);

	// table entry select
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sel_q <= '0;
		end else if (wr && reg_addr_i == A_SEL) begin
			sel_q <= reg_wdata_i[2:0];
		end
	end

	// delay and dependency tables, written through the selected entry
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NRES; i++) begin
				ton_q[i] <= TIME_RST;
				toff_q[i] <= TIME_RST;
				deps_q[i] <= DEPS_RST;
			end
		end else if (wr) begin
			if (reg_addr_i == A_TON) begin
				ton_q[sel_q] <= reg_wdata_i[TW-1:0];
			end
			if (reg_addr_i == A_TOFF) begin
				toff_q[sel_q] <= reg_wdata_i[TW-1:0];
			end
			if (reg_addr_i == A_DEPS) begin
				deps_q[sel_q] <= reg_wdata_i[NRES-1:0];
			end
		end
	end

	// core clock to resource maps, one word per core
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < NCORE; c++) begin
				clkmap_q[c] <= MAP_RST;
			end
		end else if (wr && reg_addr_i[7:4] == A_CLKMAP[7:4] && reg_addr_i[1:0] == 2'b00) begin
			clkmap_q[reg_addr_i[3:2]] <= reg_wdata_i[NRES-1:0];
		end
	end

	// =========================================================
	// demand
	assign regs_on = wlan_power_request_i | bt_power_request_i;

	// core clock requests turned into resources
	always_comb begin
		core_mask = '0;
		for (int c = 0; c < NCORE; c++) begin
			if (core_clk_req_i[c]) begin
				core_mask = core_mask | clkmap_q[c];
			end
		end
	end

	// all sources merged; nothing is asked for with both pins low
	always_comb begin
		demand = '0;
		if (regs_on) begin
			demand = min_q | core_mask;
			if (tmr_active) begin
				demand = demand | tmr_res_q;
			end
			demand[R_STBY] = 1'b1;
			demand[R_CSW] = 1'b1;
			demand[R_CLIN] = 1'b1;
			demand[R_RET] = 1'b1;
		end
	end

	// dependency closure, recomputed continuously and used on each tick
	always_comb begin
		req = demand;
		for (int p = 0; p < NRES; p++) begin
			for (int i = 0; i < NRES; i++) begin
				if (req[i]) begin
					req = req | deps_q[i];
				end
			end
		end
	end

	// =========================================================
	// sequencing decisions
	// a dependent counts as up unless fully disabled
	always_comb begin
		dep_up = '0;
		for (int i = 0; i < NRES; i++) begin
			for (int j = 0; j < NRES; j++) begin
				if (j != i && deps_q[j][i] && !st_off[j]) begin
					dep_up[i] = 1'b1;
				end
			end
		end
	end

	// every dependency must be fully enabled
	always_comb begin
		for (int i = 0; i < NRES; i++) begin
			deps_ok[i] = ((deps_q[i] & ~st_on & ~(res_mask_t'(1) << i)) == '0);
		end
	end

	// required set against status
	assign start_on = {NRES{tick}} & st_off & req & deps_ok;
	assign start_off = {NRES{tick}} & st_on & ~req & ~dep_up;

	// =========================================================
	// resource slots
	for (genvar g = 0; g < NRES; g++) begin : g_slot
		res_slot u_slot (
			.sys_clk_i(sys_clk_i),
			.rst_i(rst_i),
			.ce_i(ce_i),
			.tick_i(tick),
			.start_on_i(start_on[g]),
			.start_off_i(start_off[g]),
			.time_on_i(ton_q[g]),
			.time_off_i(toff_q[g]),
			.state_o(state[g]),
			.timer_o(timer[g])
		);
		assign st_on[g] = (state[g] == RS_ON);
		assign st_off[g] = (state[g] == RS_OFF);
		assign st_pend[g] = (state[g] == RS_UP) | (state[g] == RS_DOWN);
	end

	// =========================================================
	// mode and pins
	// doze: powered but no clock wanted by any core or timer
	assign doze = regs_on & ~|core_clk_req_i & ~tmr_active;

	// resource enables, regulators and clocks
	// leaving power-down needs a request pin; no internal path wakes it
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			res_en_o <= '0;
			core_regs_on_o <= 1'b0;
			main_clk_en_o <= 1'b0;
			deep_sleep_retention_o <= 1'b0;
			doze_o <= 1'b0;
		end else if (ce_i) begin
			res_en_o <= st_on | (st_pend & req);
			core_regs_on_o <= regs_on;
			main_clk_en_o <= st_on[R_PLL] & ~doze;
			deep_sleep_retention_o <= st_on[R_RET];
			doze_o <= doze;
		end
	end

	// section resets follow their own request once power-on reset ends
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wlan_reset_o <= 1'b1;
			bt_reset_o <= 1'b1;
		end else if (ce_i) begin
			wlan_reset_o <= ~(wlan_power_request_i & por_done);
			bt_reset_o <= ~(bt_power_request_i & por_done);
		end
	end

	// =========================================================
	// register reads, data in the following cycle only
	always_comb begin
		rd_val = '0;
		case (reg_addr_i)
			A_MIN: rd_val[NRES-1:0] = min_q;
			A_TMR_RES: rd_val[NRES-1:0] = tmr_res_q;
			A_TMR_CNT: rd_val[CW-1:0] = tmr_cnt_q;
			A_SEL: rd_val[2:0] = sel_q;
			A_TON: rd_val[TW-1:0] = ton_q[sel_q];
			A_TOFF: rd_val[TW-1:0] = toff_q[sel_q];
			A_DEPS: rd_val[NRES-1:0] = deps_q[sel_q];
			A_STATE: rd_val[NRES-1:0] = st_on;
			A_PEND: rd_val[NRES-1:0] = st_pend;
			A_STAT: begin
				rd_val[ST_REGS] = core_regs_on_o;
				rd_val[ST_WLRST] = wlan_reset_o;
				rd_val[ST_BTRST] = bt_reset_o;
				rd_val[ST_DOZE] = doze_o;
				rd_val[ST_POR] = por_done;
			end
			default: begin
				if (reg_addr_i[7:4] == A_CLKMAP[7:4] && reg_addr_i[1:0] == 2'b00) begin
					rd_val[NRES-1:0] = clkmap_q[reg_addr_i[3:2]];
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= '0;
		end else if (ce_i) begin
			reg_rdata_o <= reg_rd_i ? rd_val : 32'h00000000;
		end
	end

	// =========================================================
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	all_off_a: assert property (!regs_on |-> demand == '0 && start_on == '0)
		else $error("resources asked for with both pins low");
	regs_follow_a: assert property (ce_i |=> core_regs_on_o == $past(regs_on))
		else $error("regulator enable not following pins");
	bt_held_a: assert property (ce_i && wlan_power_request_i && !bt_power_request_i
		|=> bt_reset_o && (wlan_reset_o == !$past(por_done)))
		else $error("bluetooth not held in reset");
	release_reset_a: assert property (ce_i && por_done && wlan_power_request_i
		|=> !wlan_reset_o) else $error("wlan not released");
	enable_guard_a: assert property ((start_on & ~(st_off & req & deps_ok)) == '0)
		else $error("enable started without its conditions");
	disable_guard_a: assert property ((start_off & (req | dep_up | ~st_on)) == '0)
		else $error("disable started without its conditions");
	demand_cover_a: assert property (((demand & ~req) == '0) and (regs_on |-> req[R_RET] && req[R_CSW]))
		else $error("required set misses demand");
	core_map_a: assert property (core_clk_req_i[0] |-> (clkmap_q[0] & ~core_mask) == '0)
		else $error("core request not mapped");
	doze_clock_a: assert property (ce_i && doze |=> !main_clk_en_o)
		else $error("main clock running in doze");
	compare_a: assert property (tick && st_off[R_CSW] && req[R_CSW] && deps_ok[R_CSW]
		|-> start_on[R_CSW]) else $error("needed resource not started");

	res_up_c: cover property (tick && start_on != '0 ##[1:300] st_pend != '0);
	doze_c: cover property (ce_i && doze ##1 doze_o);
	power_down_c: cover property (core_regs_on_o ##1 !core_regs_on_o);
	reset_free_c: cover property (!wlan_reset_o && !bt_reset_o);
endmodule : pmu_resource_sequencer
`default_nettype wire

// ### rtl/por_release.sv
// power-on reset release counter
// assumes rst_i stands for the supplies still below threshold
`timescale 1ns/1ps
`default_nettype none
module por_release
	import pmu_pkg::*;
#(
	parameter int CYCLES = pmu_pkg::POR_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	output logic done_o
);
	import pmu_pkg::*;

	logic [POR_W-1:0] cnt_q;
	// =========================================================
	// count to the release point, then hold
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			done_o <= 1'b0;
		end else if (ce_i && !done_o) begin
			cnt_q <= cnt_q + 25'h0000001;
			done_o <= (cnt_q == POR_W'(CYCLES - 1));
		end
	end
endmodule : por_release
`default_nettype wire

// ### rtl/res_slot.sv
// one sequenced resource: state machine and countdown timer
// assumes start requests arrive only on a slow tick and never both at once
`timescale 1ns/1ps
`default_nettype none
module res_slot
	import pmu_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic tick_i,
	input wire logic start_on_i,
	input wire logic start_off_i,
	input wire pmu_pkg::res_time_t time_on_i,
	input wire pmu_pkg::res_time_t time_off_i,
	output pmu_pkg::res_state_t state_o,
	output pmu_pkg::res_time_t timer_o
);
	import pmu_pkg::*;

	res_state_t state_q;
	res_time_t timer_q;
	// =========================================================
	// state and timer
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_q <= RS_OFF;
			timer_q <= '0;
		end else if (ce_i) begin
			case (state_q)
				RS_OFF: if (start_on_i) begin
					if (time_on_i == '0) begin
						state_q <= RS_ON;
					end else begin
						state_q <= RS_UP;
						timer_q <= time_on_i;
					end
				end
				RS_ON: if (start_off_i) begin
					if (time_off_i == '0) begin
						state_q <= RS_OFF;
					end else begin
						state_q <= RS_DOWN;
						timer_q <= time_off_i;
					end
				end
				RS_UP, RS_DOWN: if (tick_i) begin
					timer_q <= timer_q - 8'h01;
					if (timer_q == 8'h01) begin
						state_q <= (state_q == RS_UP) ? RS_ON : RS_OFF;
					end
				end
				default: begin
					state_q <= RS_OFF;
					timer_q <= '0;
				end
			endcase
		end
	end
	assign state_o = state_q;
	assign timer_o = timer_q;
	// =========================================================
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	one_state_a: assert property ($onehot(state_q)) else $error("state not one-hot");
	timer_zero_a: assert property ((state_q == RS_ON || state_q == RS_OFF) == (timer_q == '0))
		else $error("timer/state mismatch");
	load_on_a: assert property (ce_i && state_q == RS_OFF && start_on_i && time_on_i != '0
		|=> state_q == RS_UP && timer_q == $past(time_on_i)) else $error("on-delay not loaded");
	count_down_a: assert property (tick_i && state_q != RS_ON && state_q != RS_OFF && timer_q > 8'h01
		|=> timer_q == $past(timer_q) - 8'h01) else $error("timer not decremented");
	expire_on_a: assert property (tick_i && state_q == RS_UP && timer_q == 8'h01
		|=> state_q == RS_ON) else $error("power-up did not end");
	direct_on_a: assert property (ce_i && state_q == RS_OFF && start_on_i && time_on_i == '0
		|=> state_q == RS_ON) else $error("zero on-delay not immediate");
	direct_off_a: assert property (ce_i && state_q == RS_ON && start_off_i && time_off_i == '0
		|=> state_q == RS_OFF) else $error("zero off-delay not immediate");
endmodule : res_slot
`default_nettype wire

// ### testbench/host_pins_model.sv
// host side of the two section power-request pins
// assumes bench commands change right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module host_pins_model (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic wlan_cmd_i,
	input wire logic bt_cmd_i,
	output logic wlan_power_request_o,
	output logic bt_power_request_o
);
	// =========================================================
	// pin drivers
	// pins sit at their pull-down level while the host is in reset
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wlan_power_request_o <= 1'b0;
			bt_power_request_o <= 1'b0;
		end else begin
			wlan_power_request_o <= wlan_cmd_i; // only the host ends power-down
			bt_power_request_o <= bt_cmd_i; // only the host ends power-down
		end
	end
endmodule : host_pins_model
`default_nettype wire

// ### testbench/pmu_resource_sequencer_tb_top.sv
// self-checking bench of the resource power sequencer
// assumes the host pin model; slow ticks are squeezed into a few fast cycles
`timescale 1ns/1ps
`default_nettype none
module pmu_resource_sequencer_tb_top;
	import pmu_pkg::*;
	localparam int POR_N = 20;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic low_power_osc_clock = 1'b0;
	logic wl_cmd = 1'b0;
	logic bt_cmd = 1'b0;
	logic wl_pin, bt_pin, regs_on, wl_rst, bt_rst, clk_en, retain, doze;
	logic [NCORE-1:0] core_req = '0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	res_mask_t res_en;
	int error_cnt = 0;
	int checked = 0;
	// reference state of every resource slot
	res_mask_t m_on = '0, m_up = '0, m_dn = '0, m_min = 8'h01, m_rtm = '0;
	res_time_t m_tmr [NRES] = '{default: 8'h00};
	res_time_t m_ton [NRES] = '{default: 8'h00};
	res_time_t m_toff [NRES] = '{default: 8'h00};
	res_mask_t m_deps [NRES] = '{default: 8'h00};
	res_mask_t m_map [NCORE] = '{default: 8'h00};
	logic [15:0] m_rt = 16'h0000;

	// =========================================================
	// clock and instances
	always #2.5 sys_clk_i = ~sys_clk_i;

	host_pins_model host_pins_model_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wlan_cmd_i(wl_cmd),
		.bt_cmd_i(bt_cmd), .wlan_power_request_o(wl_pin), .bt_power_request_o(bt_pin));

	pmu_resource_sequencer #(.POR_CYCLES(POR_N)) pmu_resource_sequencer_i (.sys_clk_i(sys_clk_i),
		.rst_i(rst_i), .ce_i(ce_i), .low_power_osc_clock_i(low_power_osc_clock), .wlan_power_request_i(wl_pin),
		.bt_power_request_i(bt_pin), .core_clk_req_i(core_req), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.res_en_o(res_en), .core_regs_on_o(regs_on), .wlan_reset_o(wl_rst), .bt_reset_o(bt_rst),
		.main_clk_en_o(clk_en), .deep_sleep_retention_o(retain), .doze_o(doze));

	// =========================================================
	// bus, tick and compare tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, e);
	endtask : rd

	task automatic tick();
		@(posedge sys_clk_i);
		low_power_osc_clock <= 1'b1;
		@(posedge sys_clk_i);
		low_power_osc_clock <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		#1;
	endtask : tick

	task automatic wrap_up();
		if (error_cnt == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	// =========================================================
	// reference model
	// demand closed over the dependency table
	function automatic res_mask_t req_set();
		res_mask_t r;
		r = 8'h00;
		if (wl_cmd | bt_cmd) begin
			r = 8'h27 | m_min; // forced set and minimum mask
			if (m_rt != 16'h0000) r |= m_rtm; // request timer demand
			for (int c = 0; c < NCORE; c++) if (core_req[c]) r |= m_map[c]; // core clock map
		end
		for (int k = 0; k < NRES; k++) for (int i = 0; i < NRES; i++) if (r[i]) r |= m_deps[i]; // closure
		return r;
	endfunction : req_set

	// one slow tick: decrement, expire, then start sequences from the old states
	function automatic void model_tick();
		res_mask_t rq, on0, up0, dn0, busy;
		logic hold;
		rq = req_set();
		on0 = m_on;
		up0 = m_up;
		dn0 = m_dn;
		busy = on0 | up0 | dn0;
		if (m_rt != 16'h0000) m_rt--;
		for (int i = 0; i < NRES; i++) begin
			hold = 1'b0;
			for (int j = 0; j < NRES; j++) hold |= m_deps[j][i] & busy[j];
			if (up0[i] | dn0[i]) begin
				m_tmr[i]--; // timer counts down
				if (m_tmr[i] == 8'h00) begin
					m_on[i] = up0[i]; // transition ends
					m_up[i] = 1'b0;
					m_dn[i] = 1'b0;
				end
			end else if (!on0[i] && rq[i] && (m_deps[i] & ~on0) == 8'h00) begin
				m_on[i] = (m_ton[i] == 8'h00); // direct enable
				m_up[i] = (m_ton[i] != 8'h00); // timed enable
				m_tmr[i] = m_ton[i];
			end else if (on0[i] && !rq[i] && !hold) begin
				m_on[i] = 1'b0; // disable
				m_dn[i] = (m_toff[i] != 8'h00); // timed disable
				m_tmr[i] = m_toff[i];
			end
		end
	endfunction : model_tick

	// compare outputs and status registers with the model
	task automatic check_all();
		res_mask_t rq;
		logic dz;
		rq = req_set();
		dz = (wl_cmd | bt_cmd) && core_req == '0 && m_rt == 16'h0000;
		check(32'(res_en), 32'(m_on | ((m_up | m_dn) & rq))); // enables
		check(32'(clk_en), 32'(m_on[R_PLL] & ~dz)); // main clock gated in doze
		check(32'(retain), 32'(m_on[R_RET])); // retention supply
		check(32'(doze), 32'(dz)); // doze flag
		rd(A_STATE, 32'(m_on)); // enabled mask
		rd(A_PEND, 32'(m_up | m_dn)); // pending mask
		rd(A_TMR_CNT, 32'(m_rt)); // request timer
		rd(A_STAT, {27'h0, 1'b1, dz, ~bt_cmd, ~wl_cmd, wl_cmd | bt_cmd}); // status
	endtask : check_all

	// =========================================================
	// main sequence
	initial begin
		logic [31:0] r;
		int s;
		void'($urandom(32'hD34F));
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		wl_cmd <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		#1;
		check(32'(wl_rst), 32'h1); // held before release
		check(32'(regs_on), 32'h1); // one pin keeps regulators
		rd(A_STAT, 32'h0000_000F); // status before release
		rd(A_MIN, 32'h0000_0001); // minimum mask reset
		rd(A_DEPS, 32'h0); // dependency reset
		rd(A_CLKMAP, 32'h0); // clock map reset
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40, 32'h0); // unmapped place
		wr(A_STATE, 32'hFF);
		rd(A_STATE, 32'h0); // read-only state
		@(posedge sys_clk_i) ce_i <= 1'b0;
		wr(A_MIN, 32'hFF);
		ce_i <= 1'b1;
		rd(A_MIN, 32'h1); // frozen write ignored
		repeat (POR_N) @(posedge sys_clk_i);
		#1;
		check(32'(wl_rst), 32'h0); // section released
		check(32'(bt_rst), 32'h1); // other section held
		for (int n = 0; n < 180; n++) begin
			r = $urandom;
			if (r[0]) begin
				s = $urandom_range(NRES - 1);
				m_ton[s] = 8'(r[9:8]);
				m_toff[s] = 8'(r[11:10]);
				m_deps[s] = r[23:16] & ((8'h01 << s) - 8'h01);
				wr(A_SEL, 32'(s));
				wr(A_TON, 32'(m_ton[s]));
				wr(A_TOFF, 32'(m_toff[s]));
				wr(A_DEPS, 32'(m_deps[s]));
				rd(A_TOFF, 32'(m_toff[s])); // table storage
			end
			if (r[1]) begin
				m_map[r[5:4]] = r[31:24];
				wr(A_CLKMAP + {4'h0, r[5:4], 2'b00}, 32'(m_map[r[5:4]]));
			end
			if (r[2]) begin
				m_min = r[23:16];
				wr(A_MIN, 32'(m_min));
			end
			if (r[6:3] == 4'h0) begin
				m_rtm = r[31:24];
				m_rt = 16'(r[9:8]) + 16'h0001;
				wr(A_TMR_RES, 32'(m_rtm));
				wr(A_TMR_CNT, 32'(m_rt));
			end
			@(posedge sys_clk_i);
			wl_cmd <= (r[12] | r[13]) && n < 150;
			bt_cmd <= (r[14] | r[15]) && n < 150;
			core_req <= r[19:16];
			repeat (4) @(posedge sys_clk_i);
			#1;
			check(32'(regs_on), 32'(wl_cmd | bt_cmd)); // regulators
			check(32'(wl_rst), 32'(!wl_cmd)); // section reset
			check(32'(bt_rst), 32'(!bt_cmd)); // section reset
			tick();
			model_tick();
			check_all();
		end
		wrap_up();
	end

	// watchdog against a hang
	initial begin
		#100000;
		error_cnt++;
		wrap_up();
	end
endmodule : pmu_resource_sequencer_tb_top
`default_nettype wire
